// *** rtl/clcs_core.sv ***
// Closed-loop catch-up limiter, velocity hold and current scaling core
`timescale 1ns/10ps
// How it works
// - Offset loads measured mismatch when calibration ends
// - Shared PI regulator, ramp velocity as base
// - P and I coefficients in separate registers
// - Deviation clip bounds regulator output and overshoot
// - Integrator sum limited by integral clip
// - Unclipped sum adds I times error each step
// - Catch-up enable bit activates velocity limiting
// - Overshoot only in qualified closed-loop conditions
// - Base velocity zero when ramp stopped
// - Correction follows linear PI deceleration in closed loop with catch-up enabled
// - Velocity mode needs both enable bits
// - Velocity mode clamps mismatch to 768
// - Velocity mode holds max velocity, clip permits overshoot
// - Closed-loop scaling overrides open-loop scaling
// - Target scale: min, linear ramp, max
// - Upward steps every up-delay cycles
// - Downward steps every down-delay cycles
// - Deviation is internal minus encoder minus offset
// - Tolerance defines matched deviation range
module clcs_core
  import clcs_pkg::*;
#(
  parameter int DW = 32
) (
  // Clock and reset
  input  wire logic          MCLK,
  input  wire logic          RST_B,
  // Avalon-MM slave
  input  wire logic [8:0]    AVS_ADDRESS,
  input  wire logic          AVS_READ,
  input  wire logic          AVS_WRITE,
  input  wire logic [31:0]   AVS_WRITEDATA,
  input  wire logic [3:0]    AVS_BYTEENABLE,
  output logic      [31:0]   AVS_READDATA,
  output logic               AVS_WAITREQUEST,
  // Position and ramp inputs from same-clock logic
  input  wire logic [DW-1:0] ENCODER_POSITION,
  input  wire logic [DW-1:0] RAMP_VELOCITY,
  input  wire logic          OPEN_LOOP_SCALE_IN,
  input  wire logic [7:0]    OPEN_LOOP_SCALE,
  // Outputs to ramp and driver
  output logic [DW-1:0]      INTERNAL_POSITION,
  output logic [DW-1:0]      VELOCITY_LIMIT,
  output logic               OVERSHOOT_ALLOWED,
  output logic [7:0]         ACTUAL_SCALE,
  output logic               POSITION_MATCHED
);

  // ==========================================================================
  // Register storage
  logic [31:0]     cur_cfg_q, step_cfg_q, up_dly_q, dn_dly_q;
  logic [31:0]     pi_p_q, pi_i_q, iclip_q, dvclip_q, max_velocity_q, offset_q;
  logic [31:0]     scale_reg_q;
  logic [7:0]      tol_q;
  logic [BETA_W-1:0] beta_q;
  clcs_enc_cfg_t   enc_q;
  clcs_scale_cfg_t scl;
  logic [DW-1:0]   xpos_q;
  logic            ack_q;

  // Single-cycle wait: request held one clock, answered on the next
  wire logic       req     = AVS_READ | AVS_WRITE;
  wire logic       wr_take = AVS_WRITE & ack_q;
  wire logic [6:0] idx     = AVS_ADDRESS[8:2];
  wire logic [31:0] wmask  = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                              {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // ==========================================================================
  // Deviation and mode decode
  wire logic [DW-1:0] deviation = xpos_q - ENCODER_POSITION - offset_q;
  wire logic          dev_neg   = deviation[DW-1];
  wire logic [DW-1:0] dev_abs   = dev_neg ? (~deviation + 1'b1) : deviation;
  wire logic          cl_on     = (enc_q.mode == MODE_CLOSED_LOOP);
  wire logic          matched   = dev_abs <= DW'(tol_q);
  wire logic          vhold_on  = enc_q.vlimit & enc_q.vmode;
  wire logic          calib_end = enc_q.calib & wr_take &
                                  (idx == IDX_ENC_IN_CONFIG) &
                                  AVS_BYTEENABLE[0] &
                                  ~AVS_WRITEDATA[EC_CALIB_BIT];
  wire logic          over_clamp = vhold_on & cl_on &
                                   (dev_abs > DW'(POS_CLAMP));
  wire logic [DW-1:0] clamp_pos  = dev_neg ?
                                   ENCODER_POSITION + offset_q - DW'(POS_CLAMP) :
                                   ENCODER_POSITION + offset_q + DW'(POS_CLAMP);

  // ==========================================================================
  // Register writes and internal position
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      cur_cfg_q   <= RESET_WORD;
      scale_reg_q <= RESET_WORD;
      step_cfg_q  <= RESET_WORD;
      up_dly_q    <= RESET_WORD;
      dn_dly_q    <= RESET_WORD;
      pi_p_q      <= RESET_WORD;
      pi_i_q      <= RESET_WORD;
      iclip_q     <= RESET_WORD;
      dvclip_q    <= RESET_WORD;
      max_velocity_q      <= RESET_WORD;
      offset_q    <= RESET_WORD;
      tol_q       <= 8'h00;
      beta_q      <= BETA_RESET;
      enc_q       <= '0;
      xpos_q      <= '0;
    end else begin
      if (calib_end)
        offset_q <= xpos_q - ENCODER_POSITION;
      if (over_clamp)
        xpos_q <= clamp_pos;
      if (wr_take) begin
        case (idx)
          IDX_CURRENT_CONFIG: cur_cfg_q <= merge(cur_cfg_q, AVS_WRITEDATA, wmask);
          IDX_SCALE_VALUES:   scale_reg_q <= merge(scale_reg_q, AVS_WRITEDATA, wmask);
          IDX_STEP_CONFIG:    step_cfg_q <= merge(step_cfg_q, AVS_WRITEDATA, wmask);
          IDX_SCALE_UP_DELAY: up_dly_q <= merge(up_dly_q, AVS_WRITEDATA, wmask);
          IDX_SCALE_DN_DELAY: dn_dly_q <= merge(dn_dly_q, AVS_WRITEDATA, wmask);
          IDX_MAX_VELOCITY_PI_P:      pi_p_q <= merge(pi_p_q, AVS_WRITEDATA, wmask);
          IDX_MAX_VELOCITY_PI_I:      pi_i_q <= merge(pi_i_q, AVS_WRITEDATA, wmask);
          IDX_INTEG_CLIP:     iclip_q <= merge(iclip_q, AVS_WRITEDATA, wmask);
          IDX_VEL_DEV_CLIP:   dvclip_q <= merge(dvclip_q, AVS_WRITEDATA, wmask);
          IDX_MAX_VELOCITY:   max_velocity_q <= merge(max_velocity_q, AVS_WRITEDATA, wmask);
          IDX_POS_OFFSET: begin
            if (!calib_end)
              offset_q <= merge(offset_q, AVS_WRITEDATA, wmask);
          end
          IDX_MATCH_TOL: begin
            if (AVS_BYTEENABLE[0])
              tol_q <= AVS_WRITEDATA[7:0];
          end
          IDX_MAX_COMM_ANGLE: begin
            if (AVS_BYTEENABLE[0])
              beta_q <= AVS_WRITEDATA[BETA_W-1:0];
          end
          IDX_INTERNAL_POS: begin
            if (!over_clamp)
              xpos_q <= merge(xpos_q, AVS_WRITEDATA, wmask);
          end
          IDX_ENC_IN_CONFIG: begin
            if (AVS_BYTEENABLE[0])
              enc_q <= '{mode:   AVS_WRITEDATA[EC_MODE_LO +: 2],
                         calib:  AVS_WRITEDATA[EC_CALIB_BIT],
                         vlimit: AVS_WRITEDATA[EC_VLIMIT_BIT],
                         vmode:  AVS_WRITEDATA[EC_VMODE_BIT]};
          end
          default: ;
        endcase
      end
    end
  end

  // ==========================================================================
  // PI regulator for the catch-up limit, stepped every 128 clocks
  logic [6:0]          div_q;
  logic signed [DW-1:0] isum_q;
  logic [DW-1:0]       vlim_q;
  wire logic           pi_tick = (div_q == PI_STEP_DIV);
  wire logic [DW-1:0]  base_vel = (RAMP_VELOCITY == '0) ? '0 :
                                  RAMP_VELOCITY;
  wire logic signed [DW-1:0] err = matched ? '0 : $signed(deviation);
  wire logic signed [DW+31:0] iprod = $signed(pi_i_q) * err;
  wire logic signed [DW-1:0] isum_raw = isum_q + DW'(iprod >>> PI_FRAC);
  wire logic signed [DW-1:0] iclip_s = $signed(iclip_q);
  wire logic signed [DW-1:0] isum_nxt =
      (isum_raw >  iclip_s) ? iclip_s :
      (isum_raw < -iclip_s) ? -iclip_s : isum_raw;
  wire logic signed [DW+31:0] pprod = $signed(pi_p_q) * err;
  wire logic signed [DW-1:0] vpi = DW'(pprod >>> PI_FRAC) + isum_q;
  wire logic signed [DW-1:0] dv_s = $signed(dvclip_q);
  wire logic [DW-1:0]  vpi_abs = vpi[DW-1] ? DW'(-vpi) : DW'(vpi);
  wire logic [DW-1:0]  vpi_clip = (vpi_abs > DW'(dv_s)) ? DW'(dv_s) :
                                  vpi_abs;
  // Linear deceleration falls out of the P term shrinking with deviation
  wire logic [DW-1:0]  vcorr = base_vel + vpi_clip;
  wire logic           pi_ok = (dvclip_q != '0) & (pi_p_q != '0) &
                               (pi_i_q != '0);
  wire logic           ovr = cl_on & ~matched &
                             (~enc_q.vlimit | pi_ok);
  wire logic           ovr_hold = vhold_on ? (dvclip_q != '0) & ovr : ovr;
  wire logic [DW-1:0]  vlim_d = ~(cl_on & enc_q.vlimit) ? max_velocity_q :
                                (vhold_on | ovr_hold) ?
                                (ovr_hold ? max_velocity_q + vpi_clip : max_velocity_q) :
                                ((vcorr < max_velocity_q) ? max_velocity_q : vcorr);

  // Regulator state and velocity limit output
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      div_q  <= 7'h00;
      isum_q <= '0;
      vlim_q <= '0;
    end else begin
      div_q  <= div_q + 7'h01;
      vlim_q <= vlim_d;
      if (!cl_on || matched)
        isum_q <= '0;
      else if (pi_tick)
        isum_q <= isum_nxt;
    end
  end

  // ==========================================================================
  // Target current scale from deviation
  assign scl = clcs_scale_cfg_t'(scale_reg_q[23:0]);
  wire logic [DW-1:0] thr     = DW'(scl.start_thr);
  wire logic [DW-1:0] beta_w  = DW'(beta_q);
  wire logic [8:0]    span    = {1'b0, scl.max_scale} - {1'b0, scl.min_scale};
  wire logic [DW-1:0] rng     = (beta_w > thr) ? beta_w - thr : DW'(1);
  wire logic [DW+8:0] ramp_n  = DW'(dev_abs - thr) * span;
  wire logic [7:0]    ramp_sc = scl.min_scale + 8'((ramp_n / rng));
  wire logic [7:0]    cl_tgt  = (dev_abs <= thr) ? scl.min_scale :
                                (dev_abs <= beta_w) ? ramp_sc :
                                scl.max_scale;
  wire logic          cl_scale_en = cur_cfg_q[CC_SCALE_EN_BIT];
  wire logic [7:0]    tgt = cl_scale_en ? cl_tgt :
                            (OPEN_LOOP_SCALE_IN ? OPEN_LOOP_SCALE :
                             8'hFF);

  // ==========================================================================
  // Delayed step-wise scale transitions
  logic [7:0]  scale_q;
  logic [31:0] dly_cnt_q;
  wire logic   up   = tgt > scale_q;
  wire logic   dn   = tgt < scale_q;
  wire logic [31:0] dly = up ? up_dly_q : dn_dly_q;
  wire logic   step = (dly_cnt_q + 32'h1 >= dly);

  // Counter restarts whenever the target is reached
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      scale_q   <= 8'h00;
      dly_cnt_q <= 32'h0;
    end else if (!cl_scale_en) begin
      scale_q   <= tgt;
      dly_cnt_q <= 32'h0;
    end else if ((up | dn) && dly == 32'h0) begin
      scale_q   <= tgt;
      dly_cnt_q <= 32'h0;
    end else if (up | dn) begin
      dly_cnt_q <= step ? 32'h0 : dly_cnt_q + 32'h1;
      if (step)
        scale_q <= up ? scale_q + 8'h01 : scale_q - 8'h01;
    end else
      dly_cnt_q <= 32'h0;
  end

  // ==========================================================================
  // Read mux and bus answer
  logic [31:0] rdata;
  always_comb begin
    case (idx)
      IDX_CURRENT_CONFIG: rdata = cur_cfg_q;
      IDX_SCALE_VALUES:   rdata = scale_reg_q;
      IDX_ENC_IN_CONFIG:  rdata = {27'h0, enc_q.vmode, enc_q.vlimit,
                                   enc_q.calib, enc_q.mode};
      IDX_STEP_CONFIG:    rdata = step_cfg_q;
      IDX_SCALE_UP_DELAY: rdata = up_dly_q;
      IDX_SCALE_DN_DELAY: rdata = dn_dly_q;
      IDX_MAX_COMM_ANGLE: rdata = {23'h0, beta_q};
      IDX_INTERNAL_POS:   rdata = xpos_q;
      IDX_RAMP_VELOCITY:  rdata = RAMP_VELOCITY;
      IDX_MAX_VELOCITY:   rdata = max_velocity_q;
      IDX_ENCODER_POS:    rdata = ENCODER_POSITION;
      IDX_POS_DEVIATION:  rdata = deviation;
      IDX_POS_OFFSET:     rdata = offset_q;
      IDX_MAX_VELOCITY_PI_P:      rdata = pi_p_q;
      IDX_MAX_VELOCITY_PI_I:      rdata = pi_i_q;
      IDX_CL_VEL_STATUS:  rdata = vlim_q;
      IDX_INTEG_CLIP:     rdata = iclip_q;
      IDX_VEL_DEV_CLIP:   rdata = dvclip_q;
      IDX_MATCH_TOL:      rdata = {24'h0, tol_q};
      IDX_INTEG_SUM:      rdata = isum_q;
      IDX_ACTUAL_SCALE:   rdata = {24'h0, scale_q};
      default:            rdata = 32'h0;
    endcase
  end

  // Output registers; waitrequest low one cycle after request seen
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ack_q             <= 1'b0;
      AVS_WAITREQUEST   <= 1'b1;
      AVS_READDATA      <= 32'h0;
      INTERNAL_POSITION <= '0;
      VELOCITY_LIMIT    <= '0;
      OVERSHOOT_ALLOWED <= 1'b0;
      ACTUAL_SCALE      <= 8'h00;
      POSITION_MATCHED  <= 1'b0;
    end else begin
      ack_q             <= req & ~ack_q;
      AVS_WAITREQUEST   <= ~(req & ~ack_q); // Registered from the same term as ack_q, so always equal to ~ack_q
      AVS_READDATA      <= rdata;
      INTERNAL_POSITION <= xpos_q;
      VELOCITY_LIMIT    <= vlim_q;
      OVERSHOOT_ALLOWED <= ovr_hold;
      ACTUAL_SCALE      <= scale_q;
      POSITION_MATCHED  <= matched;
    end
  end

endmodule

// *** rtl/clcs_pkg.sv ***
// Package: register map, field layout and types of the catch-up and scaling block
package clcs_pkg;

  // ==========================================================================
  // Register word indices (byte address is four times the index)
  localparam logic [6:0] IDX_CURRENT_CONFIG  = 7'h05;
  localparam logic [6:0] IDX_SCALE_VALUES    = 7'h06;
  localparam logic [6:0] IDX_ENC_IN_CONFIG   = 7'h07;
  localparam logic [6:0] IDX_STEP_CONFIG     = 7'h0A;
  localparam logic [6:0] IDX_SCALE_UP_DELAY  = 7'h18;
  localparam logic [6:0] IDX_SCALE_DN_DELAY  = 7'h19;
  localparam logic [6:0] IDX_MAX_COMM_ANGLE  = 7'h1C;
  localparam logic [6:0] IDX_INTERNAL_POS    = 7'h21;
  localparam logic [6:0] IDX_RAMP_VELOCITY   = 7'h22;
  localparam logic [6:0] IDX_MAX_VELOCITY    = 7'h24;
  localparam logic [6:0] IDX_ENCODER_POS     = 7'h50;
  localparam logic [6:0] IDX_POS_DEVIATION   = 7'h52;
  localparam logic [6:0] IDX_POS_OFFSET      = 7'h59;
  localparam logic [6:0] IDX_MAX_VELOCITY_PI_P       = 7'h5A;
  localparam logic [6:0] IDX_MAX_VELOCITY_PI_I       = 7'h5B;
  localparam logic [6:0] IDX_CL_VEL_STATUS   = 7'h5C;
  localparam logic [6:0] IDX_INTEG_CLIP      = 7'h5D;
  localparam logic [6:0] IDX_VEL_DEV_CLIP    = 7'h5E;
  localparam logic [6:0] IDX_MATCH_TOL       = 7'h5F;
  localparam logic [6:0] IDX_INTEG_SUM       = 7'h6A;
  localparam logic [6:0] IDX_ACTUAL_SCALE    = 7'h6B;

  // ==========================================================================
  // Field positions
  localparam int  CC_SCALE_EN_BIT    = 7;   // current_config scale enable
  localparam int  EC_MODE_LO         = 0;   // regulation mode [1:0]
  localparam int  EC_CALIB_BIT       = 2;   // calibration_enable
  localparam int  EC_VLIMIT_BIT      = 3;   // catchup_limit_enable
  localparam int  EC_VMODE_BIT       = 4;   // velocity_hold_enable
  localparam int  SV_MIN_LO          = 0;   // min_current_scale [7:0]
  localparam int  SV_MAX_LO          = 8;   // max_current_scale [15:8]
  localparam int  SV_START_LO        = 16;  // scale_start_threshold [23:16]
  localparam int  BETA_W             = 9;   // max_commutation_angle width

  // ==========================================================================
  // Values and counts
  localparam logic [1:0]  MODE_CLOSED_LOOP = 2'h1;
  localparam logic [31:0] POS_CLAMP        = 32'h0000_0300; // 768 usteps
  localparam logic [31:0] RESET_WORD       = 32'h0000_0000;
  localparam logic [8:0]  BETA_RESET       = 9'h0FF;
  localparam logic [6:0]  PI_STEP_DIV      = 7'h7F;   // step every 128 clocks
  localparam int          PI_FRAC          = 8;       // coefficient / 256

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [1:0]  mode;
    logic        calib;
    logic        vlimit;
    logic        vmode;
  } clcs_enc_cfg_t;

  typedef struct packed {
    logic [7:0]  start_thr;
    logic [7:0]  max_scale;
    logic [7:0]  min_scale;
  } clcs_scale_cfg_t;

endpackage

// *** tb/clcs_asserts.sv ***
// Port-level checker for the catch-up and scaling core
`timescale 1ns/10ps
module clcs_asserts
  import clcs_pkg::*;
(
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RST_B,
  // Register bus
  input wire logic [8:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  // Regulation outputs
  input wire logic        OVERSHOOT_ALLOWED,
  input wire logic [7:0]  ACTUAL_SCALE
);
  // ==========================================================================
  // Shadow of the configuration as written over the bus
  logic [4:0] cfg_q;
  logic       scl_q, dvz_q, upn_q, dnn_q;
  logic [7:0] quiet_q;
  wire        wr_ack = AVS_WRITE && !AVS_WAITREQUEST;
  wire  [6:0] idx    = AVS_ADDRESS[8:2];
  wire        quiet  = quiet_q == 8'hFF; // Outlasts one 128-clock PI step
  // Capture at the accepting edge, as the core does
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      cfg_q <= 5'h00;
      scl_q <= 1'b0;
      dvz_q <= 1'b1;
      upn_q <= 1'b0;
      dnn_q <= 1'b0;
    end else if (wr_ack) begin
      if (idx == IDX_ENC_IN_CONFIG) cfg_q <= AVS_WRITEDATA[4:0];
      if (idx == IDX_CURRENT_CONFIG) scl_q <= AVS_WRITEDATA[CC_SCALE_EN_BIT];
      if (idx == IDX_VEL_DEV_CLIP) dvz_q <= AVS_WRITEDATA == 32'h0;
      if (idx == IDX_SCALE_UP_DELAY) upn_q <= AVS_WRITEDATA != 32'h0;
      if (idx == IDX_SCALE_DN_DELAY) dnn_q <= AVS_WRITEDATA != 32'h0;
    end
  end
  // Cycles since the last write, saturating
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B || wr_ack)
      quiet_q <= 8'h00;
    else if (!quiet)
      quiet_q <= quiet_q + 8'h01;
  end
  // ==========================================================================
  // Properties
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  ack_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  ack_latency_a: assert property
    ($rose(AVS_READ || AVS_WRITE) |-> ##[1:2] !AVS_WAITREQUEST)
    else $error("bus request not answered in time");
  idle_wait_a: assert property
    (!(AVS_READ || AVS_WRITE) [*3] |-> AVS_WAITREQUEST)
    else $error("answer without a request");
  unmapped_rd_a: assert property
    (AVS_READ && !AVS_WAITREQUEST && idx == 7'h7E |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  ovs_mode_a: assert property
    (OVERSHOOT_ALLOWED && quiet |-> cfg_q[1:0] == MODE_CLOSED_LOOP)
    else $error("overshoot allowed outside closed loop");
  vhold_clip_a: assert property
    (quiet && cfg_q[3] && cfg_q[4] && dvz_q |-> !OVERSHOOT_ALLOWED)
    else $error("velocity hold exceeded with zero clip");
  scale_up_a: assert property
    (scl_q && $past(scl_q) && upn_q && ACTUAL_SCALE > $past(ACTUAL_SCALE)
     |-> ACTUAL_SCALE == $past(ACTUAL_SCALE) + 8'h01)
    else $error("delayed scale rose by more than one step");
  scale_dn_a: assert property
    (scl_q && $past(scl_q) && dnn_q && ACTUAL_SCALE < $past(ACTUAL_SCALE)
     |-> ACTUAL_SCALE == $past(ACTUAL_SCALE) - 8'h01)
    else $error("delayed scale fell by more than one step");
  cover property (OVERSHOOT_ALLOWED && cfg_q[4]);
  cover property (scl_q && upn_q && $rose(ACTUAL_SCALE == 8'h20));
  cover property (wr_ack && idx == IDX_ENC_IN_CONFIG && cfg_q[2]);
endmodule

bind clcs_core clcs_asserts i_chk (
  .MCLK(MCLK), .RST_B(RST_B), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .ACTUAL_SCALE(ACTUAL_SCALE),
  .OVERSHOOT_ALLOWED(OVERSHOOT_ALLOWED)
);

// *** tb/clcs_core_test.sv ***
// Self-checking bench for the catch-up and scaling core
`timescale 1ns/10ps
module clcs_core_test
  import clcs_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [8:0]  address = 9'h000;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] enc_tgt = 32'h0;
  logic [31:0] rdata, encoder_position, ramp_vel, int_pos, vel_lim;
  logic        waitreq, ol_in, ovs, matched;
  logic [7:0]  ol_scale, scale;
  int          error_cnt = 0;
  int          checked = 0;
  logic [6:0]  rw_idx [6] = '{IDX_MAX_VELOCITY_PI_P, IDX_MAX_VELOCITY_PI_I, IDX_INTEG_CLIP,
                              IDX_VEL_DEV_CLIP, IDX_SCALE_UP_DELAY,
                              IDX_SCALE_DN_DELAY};
  logic [31:0] sc_dev [6] = '{0, 4, 12, 20, 30, 0};
  logic [7:0]  sc_exp [6] = '{8'h10, 8'h10, 8'h18, 8'h20, 8'h20, 8'h10};

  always #4 mclk = ~mclk;

  clcs_core i_dut (
    .MCLK(mclk), .RST_B(rst_b), .AVS_ADDRESS(address), .AVS_READ(read),
    .AVS_WRITE(write), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .ENCODER_POSITION(encoder_position), .RAMP_VELOCITY(ramp_vel),
    .OPEN_LOOP_SCALE_IN(ol_in), .OPEN_LOOP_SCALE(ol_scale),
    .INTERNAL_POSITION(int_pos), .VELOCITY_LIMIT(vel_lim),
    .OVERSHOOT_ALLOWED(ovs), .ACTUAL_SCALE(scale), .POSITION_MATCHED(matched)
  );
  clcs_drive_model i_drive (
    .clk(mclk), .rst_b(rst_b), .enc_tgt(enc_tgt), .encoder_position(encoder_position),
    .ramp_vel(ramp_vel), .ol_in(ol_in), .ol_scale(ol_scale)
  );

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask
  // Held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [6:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    address <= {idx, 2'b00};
    read    <= !wr;
    write   <= wr;
    wdata   <= wd;
    // Answer and read data taken at one rising edge; watchdog ends a hang
    do
      @(posedge mclk);
    while (waitreq !== 1'b0);
    rd = rdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [6:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, idx, wd, d);
  endtask
  task automatic rd_chk(input string nm, input logic [6:0] idx,
                        input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, idx, 32'h0, d);
    chk(nm, exp, d);
  endtask
  // Ends between edges so outputs are settled
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  // Cycles until the scale reaches a value, within a window
  task automatic ramp_to(input logic [7:0] tgt, input int lo, input int hi);
    int n;
    n = 0;
    while (scale !== tgt && n < 400) begin
      @(negedge mclk);
      n++;
    end
    chk("scale ramp time", 32'h1, 32'(n >= lo && n <= hi));
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    rd_chk("enc_in reset", IDX_ENC_IN_CONFIG, RESET_WORD);
    rd_chk("angle reset", IDX_MAX_COMM_ANGLE, {23'h0, BETA_RESET});
    // Each coefficient, clip and scale delay holds its own value
    foreach (rw_idx[k]) wr(rw_idx[k], {17'h0, 8'h5A, rw_idx[k]});
    foreach (rw_idx[k]) rd_chk("rw reg", rw_idx[k], {17'h0, 8'h5A, rw_idx[k]});
    wr(7'h7E, 32'hFFFF_FFFF);
    rd_chk("unmapped", 7'h7E, 32'h0);
    // Calibration measures the mismatch as offset
    @(posedge mclk) enc_tgt <= 32'd100;
    tick(120);
    wr(IDX_INTERNAL_POS, 32'd1000);
    wr(IDX_STEP_CONFIG, 32'h0);
    wr(IDX_ENC_IN_CONFIG, 32'h05);
    tick(50);
    wr(IDX_ENC_IN_CONFIG, 32'h01);
    rd_chk("offset", IDX_POS_OFFSET, 32'd900);
    rd_chk("deviation", IDX_POS_DEVIATION, 32'h0);
    // Saved offset written directly, tolerance boundary
    wr(IDX_POS_OFFSET, 32'd850);
    rd_chk("offset write", IDX_POS_OFFSET, 32'd850);
    rd_chk("deviation", IDX_POS_DEVIATION, 32'd50);
    wr(IDX_MATCH_TOL, 32'd50);
    tick(4);
    chk("matched", 32'h1, 32'(matched));
    wr(IDX_MATCH_TOL, 32'd49);
    tick(4);
    chk("unmatched", 32'h0, 32'(matched));
    // Velocity hold needs both enables; clamp at 768
    wr(IDX_POS_OFFSET, 32'h0);
    wr(IDX_VEL_DEV_CLIP, 32'h0);
    wr(IDX_INTERNAL_POS, 32'd5000);
    wr(IDX_ENC_IN_CONFIG, 32'h09);
    tick(300);
    chk("no clamp", 32'd5000, int_pos);
    chk("zero clip", 32'h0, 32'(ovs));
    wr(IDX_ENC_IN_CONFIG, 32'h19);
    tick(300);
    chk("clamp high", 32'd868, int_pos);
    chk("hold max_velocity", 32'h0, 32'(ovs));
    wr(IDX_MAX_VELOCITY_PI_P, 32'h100);
    wr(IDX_MAX_VELOCITY_PI_I, 32'h10);
    wr(IDX_VEL_DEV_CLIP, 32'h1000);
    wr(IDX_INTEG_CLIP, 32'h10);
    tick(300);
    chk("overshoot", 32'h1, 32'(ovs));
    // Lagging motor drives the sum into its clip
    rd_chk("isum clip", IDX_INTEG_SUM, 32'h10);
    // Small clip binds: limit is max velocity plus clip
    wr(IDX_VEL_DEV_CLIP, 32'h100);
    tick(4);
    chk("dv clip", 32'h100, vel_lim);
    wr(IDX_INTERNAL_POS, 32'hFFFF_F000);
    tick(300);
    chk("clamp low", 32'hFFFF_FD64, int_pos);
    wr(IDX_ENC_IN_CONFIG, 32'h18);
    tick(300);
    chk("loop off", 32'h0, 32'(ovs));
    chk("limit off", 32'h0, vel_lim);
    // Target scale regions with immediate transitions
    wr(IDX_ENC_IN_CONFIG, 32'h01);
    wr(IDX_SCALE_UP_DELAY, 32'h0);
    wr(IDX_SCALE_DN_DELAY, 32'h0);
    wr(IDX_MAX_COMM_ANGLE, 32'd20);
    wr(IDX_SCALE_VALUES, 32'h0004_2010);
    wr(IDX_CURRENT_CONFIG, 32'h80);
    foreach (sc_dev[k]) begin
      wr(IDX_INTERNAL_POS, 32'd100 + sc_dev[k]);
      tick(8);
      chk("scale", 32'(sc_exp[k]), 32'(scale));
    end
    // Delayed steps: 16 steps of 5 up, 16 of 3 down
    wr(IDX_SCALE_UP_DELAY, 32'd5);
    wr(IDX_SCALE_DN_DELAY, 32'd3);
    wr(IDX_INTERNAL_POS, 32'd130);
    ramp_to(8'h20, 75, 90);
    wr(IDX_INTERNAL_POS, 32'd100);
    ramp_to(8'h10, 43, 58);
    give_verdict();
  end

  // Cuts a hang short well beyond the expected run
  initial begin
    repeat (12000) @(posedge mclk);
    error_cnt++;
    give_verdict();
  end
endmodule

// *** tb/clcs_drive_model.sv ***
// Encoder and driver side model feeding the core's position inputs
`timescale 1ns/10ps
module clcs_drive_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Shaft place commanded by the bench
  input  wire logic [31:0] enc_tgt,
  // Feedback to the core
  output logic      [31:0] encoder_position,
  output logic      [31:0] ramp_vel,
  output logic             ol_in,
  output logic      [7:0]  ol_scale
);
  // Shaft moves one count per clock, never jumps
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      encoder_position <= 32'h0000_0000;
    else if (encoder_position != enc_tgt)
      encoder_position <= ($signed(enc_tgt) > $signed(encoder_position)) ? encoder_position + 32'h1
                                                       : encoder_position - 32'h1;
  end
  // Ramp at rest, fixed open-loop current request
  assign ramp_vel = 32'h0000_0000;
  assign ol_in    = 1'b1;
  assign ol_scale = 8'h80;
endmodule
